// File: logic/stc_scan_counter.sv
// trigger-layer scan loop counter with register port
`timescale 1ns/100ps
// Operation
// - count reads 1..9999, infinite reads special code
// - loop one channel per pass until count
// - long count ends scan, next resumes position
// - infinite count wraps list forever
// - enabling auto loads list length
// - writing count clears auto, keeps value
// - auto bit: one on, zero off
// - auto tracks every list length change
// - empty list with auto gives one
// - delay zero to 99999.999 s, default zero
// - wait programmed delay after each event
module stc_scan_counter #(
  parameter int TICK_CYC = stc_pkg::STC_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  input wire logic scan_start,
  input wire logic chan_event,
  output logic chan_step_r,
  output logic [13:0] chan_idx_r,
  output logic layer_done_r,
  output logic busy_r
);
  import stc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // declarations
  stc_cfg_s cfg_r; // auto, infinite and channel count
  logic auto_q; // auto enable one cycle back, for edge detect
  logic [13:0] len_r; // scan-list length
  logic [13:0] len_q; // length one cycle back
  logic [26:0] delay_r; // scan_layer_delay in milliseconds
  logic [13:0] done_cnt_r; // channels stepped this scan
  stc_state_e state_r; // sequencer state
  stc_state_e state_nxt;
  logic dly_start; // kick the delay timer
  logic dly_done; // delay elapsed
  logic [13:0] ptr; // pointer from the position module
  logic wr_ctrl;
  logic wr_count;
  logic step_now;
  logic last_chan;

  // clamp a written count into the legal range
  function automatic logic [13:0] stc_clamp(input logic [31:0] v);
    if (v < 32'(STC_COUNT_MIN)) begin
      return STC_COUNT_MIN;
    end else if (v > 32'(STC_COUNT_MAX)) begin
      return STC_COUNT_MAX;
    end else begin
      return v[13:0];
    end
  endfunction : stc_clamp

  // count to use when tied to the list; empty list still scans once
  function automatic logic [13:0] stc_auto_count(input logic [13:0] n);
    if (n == '0) begin
      return STC_COUNT_MIN;
    end else if (n > STC_COUNT_MAX) begin
      return STC_COUNT_MAX;
    end else begin
      return n;
    end
  endfunction : stc_auto_count

  assign wr_ctrl = reg_wr && reg_addr == STC_CTRL_OFS;
  assign wr_count = reg_wr && reg_addr == STC_COUNT_OFS;

  //////////////////////////////////////////////////////////////////////
  // control flags: auto and infinite
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.auto_en <= 1'b0;
      cfg_r.inf_en <= 1'b0;
    end else if (wr_ctrl) begin
      cfg_r.auto_en <= reg_wdata[STC_AUTO_BIT];
      cfg_r.inf_en <= reg_wdata[STC_INF_BIT];
    end else if (wr_count) begin
      // an explicit count is finite and manual
      cfg_r.auto_en <= 1'b0;
      cfg_r.inf_en <= 1'b0;
    end
  end

  // channel count; auto follows the list length while enabled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.count <= STC_COUNT_RST;
    end else if (wr_count) begin
      cfg_r.count <= stc_clamp(reg_wdata);
    end else if (cfg_r.auto_en) begin
      // reloading every cycle covers both the enable edge and any later
      // length change; it costs nothing since manual writes win above
      cfg_r.count <= stc_auto_count(len_r);
    end
  end

  // history for edge checks
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auto_q <= 1'b0;
      len_q <= '0;
    end else begin
      auto_q <= cfg_r.auto_en;
      len_q <= len_r;
    end
  end

  // list length and delay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      len_r <= '0;
      delay_r <= STC_DELAY_RST;
    end else if (reg_wr && reg_addr == STC_LEN_OFS) begin
      len_r <= reg_wdata[13:0];
    end else if (reg_wr && reg_addr == STC_DELAY_OFS) begin
      // out of range requests saturate at the longest delay
      if (reg_wdata > 32'(STC_DELAY_MAX)) begin
        delay_r <= STC_DELAY_MAX;
      end else begin
        delay_r <= reg_wdata[26:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        STC_CTRL_OFS: begin
          reg_rdata_r <= {30'h0, cfg_r.inf_en, cfg_r.auto_en};
        end
        STC_COUNT_OFS: begin
          if (cfg_r.inf_en) begin
            reg_rdata_r <= STC_INF_CODE;
          end else begin
            reg_rdata_r <= {18'h0, cfg_r.count};
          end
        end
        STC_LEN_OFS: begin
          reg_rdata_r <= {18'h0, len_r};
        end
        STC_DELAY_OFS: begin
          reg_rdata_r <= {5'h0, delay_r};
        end
        STC_STAT_OFS: begin
          // pointer in [29:16], low count bits in [15:4], state, busy
          reg_rdata_r <= {2'h0, ptr, done_cnt_r[11:0], 1'b0,
                          state_r, busy_r};
        end
        default: begin
          reg_rdata_r <= '0; // unmapped reads as zero
        end
      endcase
    end else begin
      reg_rdata_r <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer
  assign last_chan = !cfg_r.inf_en &&
                     done_cnt_r + 14'h0001 >= cfg_r.count;
  assign step_now = state_r == STC_STEP;
  assign dly_start = state_r == STC_WAIT && chan_event;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      STC_IDLE: begin
        if (scan_start) begin
          state_nxt = STC_WAIT;
        end
      end
      STC_WAIT: begin
        if (chan_event) begin
          state_nxt = STC_DLY;
        end
      end
      STC_DLY: begin
        if (dly_done) begin
          state_nxt = STC_STEP;
        end
      end
      STC_STEP: begin
        // leave the layer only when the count is met
        state_nxt = last_chan ? STC_IDLE : STC_WAIT;
      end
      default: begin
        state_nxt = STC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= STC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // channels stepped in this scan; saturates so infinite never overflows
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_cnt_r <= '0;
    end else if (state_r == STC_IDLE && scan_start) begin
      done_cnt_r <= '0;
    end else if (step_now && done_cnt_r != STC_COUNT_MAX) begin
      done_cnt_r <= done_cnt_r + 14'h0001;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chan_step_r <= 1'b0;
      chan_idx_r <= '0;
      layer_done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      chan_step_r <= step_now;
      chan_idx_r <= ptr;
      layer_done_r <= step_now && last_chan;
      busy_r <= state_nxt != STC_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // submodules
  stc_delay_timer #(.TICK_CYC(TICK_CYC)) u_delay (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(dly_start),
    .delay_ms(delay_r),
    .done(dly_done)
  );

  stc_chan_ptr u_ptr (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .step(step_now),
    .list_len(len_r),
    .ptr(ptr)
  );

  //////////////////////////////////////////////////////////////////////
  // checks
  chk_count_range: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    cfg_r.count >= STC_COUNT_MIN && cfg_r.count <= STC_COUNT_MAX)
    else $error("channel count out of range");
  chk_inf_read: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == STC_COUNT_OFS && cfg_r.inf_en
    |=> reg_rdata_r == STC_INF_CODE)
    else $error("infinite count not reported");
  chk_done_at_count: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    step_now && !cfg_r.inf_en && done_cnt_r + 14'h0001 == cfg_r.count
    |=> layer_done_r && state_r == STC_IDLE)
    else $error("layer did not end at count");
  chk_auto_load: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    cfg_r.auto_en && !auto_q && !reg_wr
    |=> cfg_r.count == stc_auto_count($past(len_r)))
    else $error("auto enable did not load length");
  chk_write_manual: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    wr_count |=> !cfg_r.auto_en && cfg_r.count == stc_clamp($past(reg_wdata)))
    else $error("count write did not clear auto");
  chk_auto_query: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == STC_CTRL_OFS
    |=> reg_rdata_r[0] == $past(cfg_r.auto_en))
    else $error("auto query wrong");
  chk_auto_track: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    cfg_r.auto_en && auto_q && len_r != len_q && !reg_wr
    |=> cfg_r.count == stc_auto_count($past(len_r)))
    else $error("auto did not follow length");
  chk_empty_one: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    cfg_r.auto_en && len_r == '0 && !reg_wr |=> cfg_r.count == 14'h0001)
    else $error("empty list did not give one");
  chk_inf_no_end: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    step_now && cfg_r.inf_en |=> !layer_done_r)
    else $error("infinite count ended the layer");
  chk_step_waits: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    state_r == STC_DLY && !dly_done |=> state_r == STC_DLY)
    else $error("step before delay elapsed");

  cov_scan_done: cover property (@(posedge clk_sys) disable iff (!arst_n)
    layer_done_r);
  cov_inf_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    step_now && cfg_r.inf_en && ptr == len_r - 14'h0001);
  cov_auto_on: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cfg_r.auto_en && !auto_q);
endmodule : stc_scan_counter

// File: logic/stc_pkg.sv
// shared constants and types of the trigger-layer scan counter
package stc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] STC_CTRL_OFS = 8'h00;
  localparam logic [7:0] STC_COUNT_OFS = 8'h04;
  localparam logic [7:0] STC_LEN_OFS = 8'h08;
  localparam logic [7:0] STC_DELAY_OFS = 8'h0C;
  localparam logic [7:0] STC_STAT_OFS = 8'h10;
  // control field positions
  localparam int STC_AUTO_BIT = 0;
  localparam int STC_INF_BIT = 1;
  // count limits and reset values
  localparam logic [13:0] STC_COUNT_MIN = 14'h0001;
  localparam logic [13:0] STC_COUNT_MAX = 14'h270F;
  localparam logic [13:0] STC_COUNT_RST = 14'h0001;
  localparam logic [31:0] STC_INF_CODE = 32'hFFFF_FFFF;
  // delay held in milliseconds, 99999.999 s at most
  localparam logic [26:0] STC_DELAY_MAX = 27'h5F5_E0FF;
  localparam logic [26:0] STC_DELAY_RST = 27'h000_0000;
  // timing: one millisecond tick at 125 MHz
  localparam int STC_CLK_NS = 8;
  localparam int STC_TICK_NS = 1000000;
  localparam int STC_TICK_CYC = STC_TICK_NS / STC_CLK_NS;
  // scan sequencer states, gray from IDLE through STEP and back to IDLE; STEP to WAIT flips both bits
  typedef enum logic [1:0] {
    STC_IDLE = 2'b00,
    STC_WAIT = 2'b01,
    STC_DLY = 2'b11,
    STC_STEP = 2'b10
  } stc_state_e;
  // configuration carried to the sequencer
  typedef struct packed {
    logic auto_en;
    logic inf_en;
    logic [13:0] count;
  } stc_cfg_s;
endpackage : stc_pkg

// File: logic/stc_delay_timer.sv
// layer delay timer with its own millisecond tick divider
`timescale 1ns/100ps
module stc_delay_timer #(
  parameter int TICK_CYC = stc_pkg::STC_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [26:0] delay_ms,
  output logic done
);
  import stc_pkg::*;

  logic [16:0] div_r; // cycles within one millisecond
  logic [26:0] left_r; // milliseconds still to wait
  logic run_r; // timer active

  //////////////////////////////////////////////////////////////////////
  // millisecond divider, restarted with each delay so the first tick
  // lands a full millisecond after the start
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
    end else if (start || !run_r) begin
      div_r <= '0;
    end else if (div_r == 17'(TICK_CYC - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 17'h00001;
    end
  end

  // countdown; a zero delay finishes on the next edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_r <= '0;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        left_r <= delay_ms;
        run_r <= (delay_ms != '0);
        done <= (delay_ms == '0);
      end else if (run_r && div_r == 17'(TICK_CYC - 1)) begin
        left_r <= left_r - 27'h0000001;
        if (left_r == 27'h0000001) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  chk_zero_delay: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    start && delay_ms == '0 |=> done)
    else $error("zero delay did not finish at once");
  chk_delay_hold: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    start && delay_ms != '0 |=> !done [*8])
    else $error("delay ended too early");
endmodule : stc_delay_timer

// File: logic/stc_chan_ptr.sv
// scan-list position pointer that keeps its place between scans
`timescale 1ns/100ps
module stc_chan_ptr (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic step,
  input wire logic [13:0] list_len,
  output logic [13:0] ptr
);
  import stc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // advance one entry per step, wrapping after the last entry; never
  // cleared at scan start so a long count resumes where it stopped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptr <= '0;
    end else if (step) begin
      if (ptr + 14'h0001 >= list_len) begin
        ptr <= '0;
      end else begin
        ptr <= ptr + 14'h0001;
      end
    end else if (ptr >= list_len && list_len != '0) begin
      ptr <= '0; // list shrank under the pointer
    end
  end

  chk_ptr_wrap: assert property
    (@(posedge clk_sys) disable iff (!arst_n)
    step && ptr == list_len - 14'h0001 |=> ptr == '0)
    else $error("pointer did not wrap to first entry");
endmodule : stc_chan_ptr

// File: verif/stc_host_model.sv
// host controller model that drives the register port of the scan counter
`timescale 1ns/100ps
module stc_host_model (
  input wire logic clk_sys,
  input wire logic [31:0] reg_rdata_r,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // bus idles quiet from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // encodings the host uses when programming the block
  function automatic logic [31:0] auto_word(input logic on);
    return {31'h0000_0000, on};
  endfunction : auto_word
  // delay word in milliseconds, never above 99999.999 s
  function automatic logic [31:0] delay_word(input int ms);
    return (ms > 99999999) ? 32'h05F5_E0FF : 32'(ms);
  endfunction : delay_word
  //////////////////////////////////////////////////////////////////////////
  // one-cycle write; data inverted after so a stale word is never reused
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one-cycle read; data taken in the single cycle where it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask : rd
endmodule : stc_host_model

// File: verif/scan_trigger_layer_counter_test.sv
// self-checking bench of the scan counter against an integer model
`timescale 1ns/100ps
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module scan_trigger_layer_counter_test;
  import stc_pkg::*;
  localparam int TICK = 4; // short millisecond for simulation
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r, rv;
  logic reg_wr, reg_rd, chan_step_r, layer_done_r, busy_r;
  logic scan_start = 1'b0;
  logic chan_event = 1'b0;
  logic [13:0] chan_idx_r;
  int failures = 0;
  int n_compared = 0;
  // integer model of the programmed state
  int m_cnt = 1, m_auto = 0, m_inf = 0, m_len = 0, m_dly = 0, m_ptr = 0;
  int m_done, lat, i;
  logic [31:0] seed = 32'hdc91652b;
  always #4 clk_sys = ~clk_sys;
  stc_scan_counter #(.TICK_CYC(TICK)) u_stc_scan_counter (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .scan_start(scan_start), .chan_event(chan_event),
    .chan_step_r(chan_step_r), .chan_idx_r(chan_idx_r),
    .layer_done_r(layer_done_r), .busy_r(busy_r));
  stc_host_model u_stc_host_model (.clk_sys(clk_sys),
    .reg_rdata_r(reg_rdata_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  //////////////////////////////////////////////////////////////////////////
  // xorshift source, bounded to 1..lim
  function automatic int rnd(input int lim);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 32'(lim)) + 1;
  endfunction : rnd
  // write through the host and mirror it in the model
  task automatic put(input logic [7:0] a, input int d);
    u_stc_host_model.wr(a, 32'(d));
    case (a)
      STC_CTRL_OFS: begin
        m_auto = d & 1;
        m_inf = (d >> 1) & 1;
      end
      STC_COUNT_OFS: begin
        m_cnt = (d < 1) ? 1 : (d > 9999) ? 9999 : d;
        m_auto = 0;
        m_inf = 0;
      end
      STC_LEN_OFS: m_len = d & 16'h3FFF;
      STC_DELAY_OFS: m_dly = (d > 99999999) ? 99999999 : d;
      default: ;
    endcase
    if (m_auto == 1) m_cnt = (m_len == 0) ? 1 : (m_len > 9999) ? 9999 : m_len;
    if (m_ptr >= m_len) m_ptr = 0;
    repeat (2) @(posedge clk_sys); // auto reload lands a cycle late
  endtask : put
  // read and compare against the model
  task automatic look(input logic [7:0] a);
    logic [31:0] w;
    case (a)
      STC_CTRL_OFS: w = 32'((m_inf << 1) | m_auto);
      STC_COUNT_OFS: w = (m_inf == 1) ? STC_INF_CODE : 32'(m_cnt);
      STC_LEN_OFS: w = 32'(m_len);
      STC_DELAY_OFS: w = 32'(m_dly);
      // status as seen while idle: pointer and low bits of channels done
      STC_STAT_OFS: w = 32'((m_ptr << 16) | ((m_done % 4096) << 4));
      default: w = 32'h0000_0000;
    endcase
    u_stc_host_model.rd(a, rv);
    `CHK(rv, w)
  endtask : look
  // one trigger-layer event; step, index and exit compared with the model
  task automatic chan();
    @(posedge clk_sys);
    chan_event <= 1'b1;
    @(posedge clk_sys);
    chan_event <= 1'b0;
    #1;
    lat = 1;
    while (chan_step_r !== 1'b1 && lat < 2000) begin
      @(posedge clk_sys);
      #1;
      lat++;
    end
    // a step that never comes is a mismatch of its own
    if (lat >= 2000) failures++;
    m_done++;
    `CHK(chan_idx_r, 14'(m_ptr))
    `CHK(layer_done_r, logic'(m_inf == 0 && m_done == m_cnt))
    `CHK(busy_r, logic'(!(m_inf == 0 && m_done == m_cnt)))
    m_ptr = (m_ptr + 1) % m_len;
  endtask : chan
  // enter the trigger layer and run n events
  task automatic scan(input int n);
    @(posedge clk_sys);
    scan_start <= 1'b1;
    @(posedge clk_sys);
    scan_start <= 1'b0;
    m_done = 0;
    for (int k = 0; k < n; k++) chan();
  endtask : scan
  //////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // watchdog well beyond the expected run
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    // reset values, unmapped place
    look(STC_COUNT_OFS);
    look(STC_CTRL_OFS);
    look(STC_DELAY_OFS);
    put(8'h14, 32'h1234);
    look(8'h14);
    // count limits and random finite counts
    put(STC_COUNT_OFS, 0);
    look(STC_COUNT_OFS);
    put(STC_COUNT_OFS, 10000);
    look(STC_COUNT_OFS);
    for (i = 0; i < 4; i++) begin
      put(STC_COUNT_OFS, rnd(9999));
      look(STC_COUNT_OFS);
    end
    // auto count: empty list, load, tracking, clear by count write
    put(STC_CTRL_OFS, u_stc_host_model.auto_word(1'b1));
    look(STC_COUNT_OFS);
    look(STC_CTRL_OFS);
    for (i = 0; i < 3; i++) begin
      put(STC_LEN_OFS, rnd(40));
      look(STC_COUNT_OFS);
    end
    put(STC_CTRL_OFS, u_stc_host_model.auto_word(1'b0));
    put(STC_LEN_OFS, 3);
    put(STC_CTRL_OFS, u_stc_host_model.auto_word(1'b1));
    look(STC_COUNT_OFS);
    put(STC_COUNT_OFS, 5);
    look(STC_CTRL_OFS);
    look(STC_COUNT_OFS);
    // count longer than the list, then a scan that resumes
    scan(5);
    put(STC_COUNT_OFS, 2);
    scan(2);
    look(STC_STAT_OFS);
    // delay limits and a timed event; the first write must saturate
    put(STC_DELAY_OFS, 100000000);
    look(STC_DELAY_OFS);
    put(STC_DELAY_OFS, u_stc_host_model.delay_word(99999999));
    look(STC_DELAY_OFS);
    put(STC_DELAY_OFS, 2);
    put(STC_COUNT_OFS, 1);
    scan(1);
    `CHK(logic'(lat >= 2 * TICK && lat <= 2 * TICK + 6), 1'b1)
    put(STC_DELAY_OFS, 0);
    // infinite count wraps and never leaves the layer
    put(STC_CTRL_OFS, 2);
    look(STC_COUNT_OFS);
    scan(8);
    tally_and_finish();
  end
endmodule : scan_trigger_layer_counter_test
